// *** core/act_trim_bank.sv ***
// APB slave holding channel 1 gain trim and channel 2 setup and trims
`include "act_regs.svh"

// Notes on behaviour
// - each 24-bit gain trim keeps its upper sixteen bits in the whole high gain word.
// - the lowest eight gain trim bits sit in bits 15 to 8 of the low gain word.
// - the gain trim is an unsigned fraction giving a multiplier from zero to just under two.
// - the high gain word resets to 8000h so the combined trim starts at unity.
// - the 24-bit offset trim is signed two's complement with its upper sixteen bits in the high offset word.
// - the lowest eight offset trim bits sit in bits 15 to 8 of the low offset word.
// - setup bits 15 to 6 form a signed channel delay in modulator clock cycles.
// - setup bit 2 at 0 follows the global dc filter setting and at 1 bypasses the filter for this channel.
// - setup bits 1 to 0 pick normal pins, shorted inputs, positive test level or negative test level.
// - the setup word resets to zero, giving no delay, global filter control and normal pins.
module act_trim_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic global_dc_filter_setting,
  output act_pkg::act_trim_type trim_ff,
  output act_pkg::act_setup_type setup_ff,
  output logic ch2_dc_filter_active_ff,
  output logic ch2_positive_pin_connect_ff,
  output logic ch2_negative_pin_connect_ff,
  output logic ch2_inputs_shorted_ff,
  output logic ch2_test_pos_ff,
  output logic ch2_test_neg_ff
);
  // ==========================================================
  // address decode
  localparam int NREG = 7;
  logic [15:0] word [NREG];
  logic [NREG-1:0] wr_sel;
  logic access_phase;
  logic commit_phase;
  logic idx_hit;
  logic [2:0] idx_num;
  logic [7:0] idx;

  function automatic logic [2:0] act_index(input logic [7:0] reg_idx);
    act_index = 3'(reg_idx - `ACT_IDX_CH1_GAIN_HI);
  endfunction : act_index

  // pready follows the first access cycle; a write lands only at the edge that sees pready
  assign access_phase = psel && penable && !pready_ff;
  assign commit_phase = psel && penable && pready_ff;
  assign idx = paddr[9:2];
  assign idx_hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                   (idx >= `ACT_IDX_CH1_GAIN_HI) && (idx <= `ACT_IDX_CH2_GAIN_LO);
  assign idx_num = act_index(idx);

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      // a word is written only when both of its low byte lanes are strobed
      wr_sel[i] = commit_phase && pwrite && idx_hit && (pstrb[1:0] == 2'h3) && (idx_num == 3'(i));
    end
  end

  // ==========================================================
  // register words
  act_word_reg #(.RESET_VALUE(`ACT_RST_GAIN_HI), .WRITE_MASK(16'hFFFF)) u_ch1_gain_hi (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_sel[0]), .wr_data(pwdata[15:0]), .value_ff(word[0]));
  act_word_reg #(.RESET_VALUE(`ACT_RST_ZERO), .WRITE_MASK(`ACT_MASK_LO)) u_ch1_gain_lo (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_sel[1]), .wr_data(pwdata[15:0]), .value_ff(word[1]));
  act_word_reg #(.RESET_VALUE(`ACT_RST_ZERO), .WRITE_MASK(`ACT_MASK_SETUP)) u_ch2_setup (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_sel[2]), .wr_data(pwdata[15:0]), .value_ff(word[2]));
  act_word_reg #(.RESET_VALUE(`ACT_RST_ZERO), .WRITE_MASK(16'hFFFF)) u_ch2_ofs_hi (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_sel[3]), .wr_data(pwdata[15:0]), .value_ff(word[3]));
  act_word_reg #(.RESET_VALUE(`ACT_RST_ZERO), .WRITE_MASK(`ACT_MASK_LO)) u_ch2_ofs_lo (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_sel[4]), .wr_data(pwdata[15:0]), .value_ff(word[4]));
  act_word_reg #(.RESET_VALUE(`ACT_RST_GAIN_HI), .WRITE_MASK(16'hFFFF)) u_ch2_gain_hi (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_sel[5]), .wr_data(pwdata[15:0]), .value_ff(word[5]));
  act_word_reg #(.RESET_VALUE(`ACT_RST_ZERO), .WRITE_MASK(`ACT_MASK_LO)) u_ch2_gain_lo (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_sel[6]), .wr_data(pwdata[15:0]), .value_ff(word[6]));

  // ==========================================================
  // bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access_phase;
      pslverr_ff <= access_phase && !idx_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (access_phase && !pwrite && idx_hit) begin
      prdata_ff <= {16'h0000, word[idx_num]};
    end else begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // decoded trims and setup toward the signal chain
  logic [23:0] ch1_gain_full;
  logic [23:0] ch2_gain_full;
  logic [23:0] ch2_ofs_full;
  act_pkg::act_setup_type setup_now;

  assign ch1_gain_full = {word[0], word[1][`ACT_LO_FIELD_MSB:`ACT_LO_FIELD_LSB]};
  assign ch2_gain_full = {word[5], word[6][`ACT_LO_FIELD_MSB:`ACT_LO_FIELD_LSB]};
  assign ch2_ofs_full = {word[3], word[4][`ACT_LO_FIELD_MSB:`ACT_LO_FIELD_LSB]};
  assign setup_now = '{
    ch2_sample_delay: word[2][`ACT_DELAY_MSB:`ACT_DELAY_LSB],
    ch2_dc_filter_bypass: word[2][`ACT_BYPASS_BIT],
    ch2_input_select: act_pkg::act_input_type'(word[2][`ACT_SEL_MSB:`ACT_SEL_LSB])
  };

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_ff <= '{ch1_gain: {`ACT_RST_GAIN_HI, 8'h00}, ch2_gain: {`ACT_RST_GAIN_HI, 8'h00}, ch2_offset: 24'h000000};
      setup_ff <= '0;
    end else begin
      trim_ff <= '{ch1_gain: ch1_gain_full, ch2_gain: ch2_gain_full, ch2_offset: ch2_ofs_full};
      setup_ff <= setup_now;
    end
  end

  // filter runs only when global setting enables it and channel is not bypassed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_dc_filter_active_ff <= 1'b0;
    end else begin
      ch2_dc_filter_active_ff <= global_dc_filter_setting && !setup_now.ch2_dc_filter_bypass;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_positive_pin_connect_ff <= 1'b1;
      ch2_negative_pin_connect_ff <= 1'b1;
      ch2_inputs_shorted_ff <= 1'b0;
      ch2_test_pos_ff <= 1'b0;
      ch2_test_neg_ff <= 1'b0;
    end else begin
      ch2_positive_pin_connect_ff <= 1'b0;
      ch2_negative_pin_connect_ff <= 1'b0;
      ch2_inputs_shorted_ff <= 1'b0;
      ch2_test_pos_ff <= 1'b0;
      ch2_test_neg_ff <= 1'b0;
      case (setup_now.ch2_input_select)
        act_pkg::ACT_IN_NORMAL: begin
          ch2_positive_pin_connect_ff <= 1'b1;
          ch2_negative_pin_connect_ff <= 1'b1;
        end
        act_pkg::ACT_IN_SHORT: begin
          ch2_inputs_shorted_ff <= 1'b1;
        end
        act_pkg::ACT_IN_TEST_POS: begin
          ch2_test_pos_ff <= 1'b1;
        end
        act_pkg::ACT_IN_TEST_NEG: begin
          ch2_test_neg_ff <= 1'b1;
        end
        default: begin
          ch2_positive_pin_connect_ff <= 1'b1;
          ch2_negative_pin_connect_ff <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // assertions
  // every register word side by side, so one check catches a stray write anywhere
  logic [16*NREG-1:0] word_flat;
  assign word_flat = {word[6], word[5], word[4], word[3], word[2], word[1], word[0]};

  // ==========================================================
  // trim assembly toward the signal chain
  // trims lag their words by one cycle
  AST_GAIN_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> trim_ff.ch1_gain[23:8] == $past(word[0]))
    else $error("ch1 gain upper bits do not follow high word");
  AST_GAIN2_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> trim_ff.ch2_gain[23:8] == $past(word[5]))
    else $error("ch2 gain upper bits do not follow high word");
  AST_GAIN_LOWER: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> trim_ff.ch2_gain[7:0] == $past(word[6][15:8]))
    else $error("ch2 gain lower bits do not follow low word upper byte");
  AST_GAIN1_LOWER: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> trim_ff.ch1_gain[7:0] == $past(word[1][15:8]))
    else $error("ch1 gain lower bits do not follow low word upper byte");
  AST_GAIN_UNITY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> word[0] == 16'h8000 && word[5] == 16'h8000)
    else $error("gain high word not at unity after reset");
  AST_TRIM_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> trim_ff.ch1_gain == {`ACT_RST_GAIN_HI, 8'h00} &&
      trim_ff.ch2_gain == {`ACT_RST_GAIN_HI, 8'h00} && trim_ff.ch2_offset == 24'h000000)
    else $error("trims not at their reset values after reset");
  AST_OFFSET_SIGN: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> trim_ff.ch2_offset[23] == $past(word[3][15]))
    else $error("offset sign bit not from high offset word");
  AST_OFFSET_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> trim_ff.ch2_offset[23:8] == $past(word[3]))
    else $error("offset upper bits do not follow high offset word");
  AST_OFFSET_LOWER: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> trim_ff.ch2_offset[7:0] == $past(word[4][15:8]))
    else $error("offset lower bits wrong");
  AST_WRITE_LANDS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_sel[0] |=> word[0] == $past(pwdata[15:0]))
    else $error("ch1 high gain word did not take the write");

  // ==========================================================
  // channel setup and input routing
  // routing outputs are one-hot apart from the pin pair, which moves together
  AST_DELAY_FIELD: assert property (@(posedge pclk) disable iff (!presetn)
    wr_sel[2] |=> ##1 setup_ff.ch2_sample_delay == $past(pwdata[15:6], 2))
    else $error("sample delay not taken from setup bits 15 to 6");
  AST_DELAY_SIGN: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> setup_ff.ch2_sample_delay[9] == $past(word[2][`ACT_DELAY_MSB]))
    else $error("sample delay sign not from setup bit 15");
  AST_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
    word[2][2] |=> !ch2_dc_filter_active_ff)
    else $error("dc filter active while bypassed");
  AST_FILTER_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    !word[2][`ACT_BYPASS_BIT] |=> ch2_dc_filter_active_ff == $past(global_dc_filter_setting))
    else $error("dc filter does not follow the global setting");
  AST_INPUT_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    word[2][1:0] == 2'h1 |=> ch2_inputs_shorted_ff && !ch2_positive_pin_connect_ff)
    else $error("shorted input select not applied");
  AST_SEL_NORMAL: assert property (@(posedge pclk) disable iff (!presetn)
    word[2][1:0] == 2'h0 |=> ch2_positive_pin_connect_ff && ch2_negative_pin_connect_ff && !ch2_inputs_shorted_ff)
    else $error("normal pins not connected");
  AST_SEL_POS: assert property (@(posedge pclk) disable iff (!presetn)
    word[2][1:0] == 2'h2 |=> ch2_test_pos_ff && !ch2_test_neg_ff && !ch2_positive_pin_connect_ff)
    else $error("positive test level not applied");
  AST_SEL_NEG: assert property (@(posedge pclk) disable iff (!presetn)
    word[2][1:0] == 2'h3 |=> ch2_test_neg_ff && !ch2_test_pos_ff && !ch2_negative_pin_connect_ff)
    else $error("negative test level not applied");
  AST_SEL_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |-> ch2_positive_pin_connect_ff == ch2_negative_pin_connect_ff &&
      $onehot({ch2_positive_pin_connect_ff, ch2_inputs_shorted_ff, ch2_test_pos_ff, ch2_test_neg_ff}))
    else $error("more than one input routing active");
  AST_SETUP_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> word[2] == `ACT_RST_ZERO && setup_ff == '0)
    else $error("setup not zero after reset");
  AST_PIN_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ch2_positive_pin_connect_ff && ch2_negative_pin_connect_ff && !ch2_inputs_shorted_ff)
    else $error("normal pins not selected after reset");

  // ==========================================================
  // reserved ranges
  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    word[1][7:0] == 8'h00 && word[4][7:0] == 8'h00 && word[6][7:0] == 8'h00 && word[2][5:3] == 3'h0)
    else $error("reserved bits not zero");
  AST_LOW_READ: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && !pwrite && idx_hit && (idx_num == 3'h1 || idx_num == 3'h4 || idx_num == 3'h6)
      |=> prdata_ff[7:0] == 8'h00)
    else $error("low trim word read with reserved byte set");
  AST_UPPER_READ: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |-> prdata_ff[31:16] == 16'h0000)
    else $error("unused read data bits not zero");

  // ==========================================================
  // bus handshake
  // a refused or partial write must leave every word as it was
  AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> ##[0:1] pready_ff)
    else $error("access not answered within one cycle");
  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready_ff |=> !pready_ff)
    else $error("pready held longer than one cycle");
  AST_IDLE_NO_READY: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> !pready_ff)
    else $error("pready without a selected access");
  AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_ff |-> pready_ff)
    else $error("error flag without pready");
  AST_RDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !pready_ff |-> prdata_ff == 32'h0000_0000)
    else $error("read data not zero outside the answer cycle");
  AST_READ_ZERO_BAD: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_ff |-> prdata_ff == 32'h0000_0000)
    else $error("refused read returned data");
  AST_STROBE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    commit_phase && pwrite && pstrb[1:0] != 2'h3 |=> $stable(word_flat))
    else $error("partial strobe write changed a word");
  AST_BAD_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    commit_phase && !idx_hit |=> $stable(word_flat))
    else $error("refused address changed a word");

  // main scenarios
  COV_WRITE_SETUP: cover property (@(posedge pclk) disable iff (!presetn) wr_sel[2]);
  COV_READ_GAIN: cover property (@(posedge pclk) disable iff (!presetn)
    access_phase && !pwrite && idx_hit && idx_num == 3'h0);
  COV_BAD_ADDR: cover property (@(posedge pclk) disable iff (!presetn) pslverr_ff);
  COV_TEST_NEG: cover property (@(posedge pclk) disable iff (!presetn) ch2_test_neg_ff);
  COV_PARTIAL_STROBE: cover property (@(posedge pclk) disable iff (!presetn)
    commit_phase && pwrite && pstrb[1:0] != 2'h3);
endmodule : act_trim_bank

// *** core/act_regs.svh ***
// register offsets, field positions, reset values for the channel trim bank
`ifndef ACT_REGS_SVH
`define ACT_REGS_SVH
// printed offsets are word indices; byte address is four times the index
`define ACT_IDX_CH1_GAIN_HI 8'h11
`define ACT_IDX_CH1_GAIN_LO 8'h12
`define ACT_IDX_CH2_SETUP 8'h13
`define ACT_IDX_CH2_OFS_HI 8'h14
`define ACT_IDX_CH2_OFS_LO 8'h15
`define ACT_IDX_CH2_GAIN_HI 8'h16
`define ACT_IDX_CH2_GAIN_LO 8'h17
`define ACT_RST_GAIN_HI 16'h8000
`define ACT_RST_ZERO 16'h0000
`define ACT_LO_FIELD_MSB 15
`define ACT_LO_FIELD_LSB 8
`define ACT_DELAY_MSB 15
`define ACT_DELAY_LSB 6
`define ACT_BYPASS_BIT 2
`define ACT_SEL_MSB 1
`define ACT_SEL_LSB 0
`define ACT_MASK_LO 16'hFF00
`define ACT_MASK_SETUP 16'hFFC7
`endif

// *** core/act_pkg.sv ***
// types shared by the channel trim bank
package act_pkg;
  typedef enum logic [1:0] {
    ACT_IN_NORMAL = 2'h0,
    ACT_IN_SHORT = 2'h1,
    ACT_IN_TEST_POS = 2'h2,
    ACT_IN_TEST_NEG = 2'h3
  } act_input_type;

  typedef struct packed {
    logic signed [9:0] ch2_sample_delay;
    logic ch2_dc_filter_bypass;
    act_input_type ch2_input_select;
  } act_setup_type;

  typedef struct packed {
    logic [23:0] ch1_gain;
    logic [23:0] ch2_gain;
    logic signed [23:0] ch2_offset;
  } act_trim_type;
endpackage : act_pkg

// *** core/act_word_reg.sv ***
// one 16-bit trim word with a writable-bit mask and reset value
module act_word_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value_ff
);
  // reserved bits keep their reset value and ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= RESET_VALUE & WRITE_MASK;
    end else if (wr_en) begin
      value_ff <= wr_data & WRITE_MASK;
    end
  end
endmodule : act_word_reg

// *** testbench/act_trim_bank_bench.sv ***
// self-checking testbench for the channel trim register bank
`include "act_regs.svh"
module act_trim_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, glob = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, fact, ppin, npin, shrt, tpos, tneg;
  act_pkg::act_trim_type trim_ff;
  act_pkg::act_setup_type setup_ff;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [15:0] lf = 16'hF7BB;
  logic [15:0] w[7];
  logic [7:0] idx[7] = '{`ACT_IDX_CH1_GAIN_HI, `ACT_IDX_CH1_GAIN_LO, `ACT_IDX_CH2_SETUP, `ACT_IDX_CH2_OFS_HI,
    `ACT_IDX_CH2_OFS_LO, `ACT_IDX_CH2_GAIN_HI, `ACT_IDX_CH2_GAIN_LO};
  logic [15:0] rst[7] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  logic [15:0] msk[7] = '{16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};
  int n_mismatch = 0, num_checks = 0;
  act_trim_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .global_dc_filter_setting(glob), .trim_ff(trim_ff), .setup_ff(setup_ff),
    .ch2_dc_filter_active_ff(fact), .ch2_positive_pin_connect_ff(ppin), .ch2_negative_pin_connect_ff(npin),
    .ch2_inputs_shorted_ff(shrt), .ch2_test_pos_ff(tpos), .ch2_test_neg_ff(tneg));
  always #5 pclk = ~pclk;
  // ==========================================
  // helpers
  function automatic logic [15:0] nxt_lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt_lf
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  // apb master: setup, access until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
      input logic [32:0] exp);
    int n;
    n = 0;
    q.push_back(exp);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b1, 1'b0, "no pready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ba
  task automatic read_all();
    for (int i = 0; i < 7; i++) apb(1'b0, ba(idx[i]), 16'h0000, 4'hF, {1'b0, 16'h0000, w[i] & msk[i]});
    chk({9'h0, trim_ff.ch1_gain}, {9'h0, w[0], w[1][15:8]}, "ch1 gain");
    chk({9'h0, trim_ff.ch2_offset}, {9'h0, w[3], w[4][15:8]}, "ch2 offset");
    chk({9'h0, trim_ff.ch2_gain}, {9'h0, w[5], w[6][15:8]}, "ch2 gain");
    chk({23'h0, setup_ff.ch2_sample_delay}, {23'h0, w[2][15:6]}, "delay");
  endtask : read_all
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    w = rst;
    read_all();
    chk({27'h0, fact, ppin, npin, shrt, tpos, tneg}, {27'h0, glob, 5'h18}, "reset pins");
    $display("test reset done");
  endtask : do_reset
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // ==========================================
  // monitor: each answer is compared with the oldest note
  always @(posedge pclk) begin
    if (pready_ff === 1'b1) begin
      if (q.size() == 0) chk(1'b1, 1'b0, "unexpected pready");
      else begin
        e = q.pop_front();
        chk({pslverr_ff, prdata_ff}, e, "apb answer");
      end
    end
  end
  initial begin
    #200000;
    chk(1'b1, 1'b0, "watchdog");
    complete_run();
  end
  // ==========================================
  // scenarios
  initial begin
    do_reset();
    for (int i = 0; i < 7; i++) begin
      lf = nxt_lf(lf);
      apb(1'b1, ba(idx[i]), lf, 4'hF, 33'h0);
      w[i] = lf;
    end
    read_all();
    $display("test random words done");
    apb(1'b1, ba(idx[0]), 16'hFFFF, 4'hF, 33'h0);
    apb(1'b1, ba(idx[1]), 16'hFFFF, 4'hF, 33'h0);
    @(posedge pclk);
    chk({9'h0, trim_ff.ch1_gain}, {9'h0, 24'hFFFFFF}, "gain max");
    w[0] = 16'hFFFF;
    w[1] = 16'hFFFF;
    for (int k = 0; k < 16; k++) begin
      lf = nxt_lf(lf);
      glob <= k[3];
      w[2] = {lf[15:6], 3'h7, k[2], k[1:0]};
      apb(1'b1, ba(idx[2]), w[2], 4'hF, 33'h0);
      @(posedge pclk);
      chk({32'h0, fact}, {32'h0, k[3] & ~k[2]}, "filter");
      chk({27'h0, ppin, npin, shrt, tpos, tneg}, {27'h0, k[1:0] == 2'h0, k[1:0] == 2'h0, k[1:0] == 2'h1,
        k[1:0] == 2'h2, k[1:0] == 2'h3}, "select");
      chk({30'h0, setup_ff.ch2_dc_filter_bypass, setup_ff.ch2_input_select}, {30'h0, k[2:0]}, "setup");
      apb(1'b0, ba(idx[2]), 16'h0000, 4'hF, {17'h0, w[2] & 16'hFFC7});
    end
    $display("test setup modes done");
    apb(1'b1, ba(idx[3]), 16'h1234, 4'h1, 33'h0);
    apb(1'b1, ba(8'h18), 16'h5555, 4'hF, {1'b1, 32'h0});
    apb(1'b1, ba(idx[5]) + 12'h001, 16'h5555, 4'hF, {1'b1, 32'h0});
    apb(1'b0, 12'h800 | ba(idx[0]), 16'h0000, 4'hF, {1'b1, 32'h0});
    apb(1'b0, ba(8'h10), 16'h0000, 4'hF, {1'b1, 32'h0});
    read_all();
    $display("test refusals done");
    do_reset();
    complete_run();
  end
endmodule : act_trim_bank_bench
